// file: bench/test_weigh_io_function_mapper.sv
`timescale 1ns/10ps
`include "wiom_consts.vh"
module test_weigh_io_function_mapper;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, stable, tare_evt, zero_evt, e;
   logic [1:0] sw_cmd = 2'h0, din;
   logic signed [23:0] wt_cmd = 24'sh0, gross_wt;
   logic stb_cmd = 1'b1;
   logic [2:0] flt_cmd = 3'h0, fault_flags;
   logic [3:0] dout;
   int n_errors = 0, check_count = 0, n_tare = 0, n_zero = 0, cyc = 0;
   // short debounce keeps the run brief; edge latency budgets below assume it
   wiom_top #(.DEB_CYC(2)) wiom_top_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .din(din), .gross_wt(gross_wt), .stable(stable), .fault_flags(fault_flags), .dout(dout),
      .tare_evt(tare_evt), .zero_evt(zero_evt));
   wiom_plant wiom_plant_i (.ref_clk(ref_clk), .sw_cmd(sw_cmd), .wt_cmd(wt_cmd), .stb_cmd(stb_cmd),
      .flt_cmd(flt_cmd), .din(din), .gross_wt(gross_wt), .stable(stable), .fault_flags(fault_flags));
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (tare_evt === 1'b1) n_tare++;
      if (zero_evt === 1'b1) n_zero++;
      if (cyc == 20000) begin
         n_errors++;
         wrap_up;
      end
   end
   task wrap_up;
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // values read right after the edge are the ones sampled at it
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk("write error", 32'h0, {31'h0, e});
   endtask
   task rd(input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk("read data", ex, q);
   endtask
   task pulses(input logic [1:0] sw, input int et, input int ez);
      n_tare = 0;
      n_zero = 0;
      sw_cmd <= sw;
      repeat (40) @(posedge ref_clk);
      chk("tare pulses", et, n_tare);
      chk("zero pulses", ez, n_zero);
   endtask
   task dchk(input logic [3:0] ex);
      for (int i = 0; i < 20 && dout !== ex; i++) @(posedge ref_clk);
      chk("dout", {28'h0, ex}, {28'h0, dout});
   endtask
   task zt(input logic [31:0] m, input logic [23:0] w, input int ex);
      wr(`WIOM_A_MODE, m);
      wt_cmd <= w;
      pulses(2'h1, 0, ex);
      pulses(2'h0, 0, 0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      chk("dout after reset", 32'h0, {28'h0, dout});
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      wr(`WIOM_A_CAP, 32'h3E8);
      rd(`WIOM_A_CAP, 32'h3E8);
      wr(`WIOM_A_INCFG, 32'h21);
      pulses(2'h1, 1, 0);
      pulses(2'h0, 0, 0);
      wr(`WIOM_A_INCFG, 32'h31);
      pulses(2'h1, 0, 0);
      pulses(2'h0, 1, 0);
      wr(`WIOM_A_INCFG, 32'h2121);
      pulses(2'h2, 1, 0);
      pulses(2'h3, 1, 0);
      pulses(2'h0, 0, 0);
      wr(`WIOM_A_INCFG, 32'h0);
      pulses(2'h3, 0, 0);
      pulses(2'h0, 0, 0);
      dchk(4'h0);
      wt_cmd <= 24'sh1F4;
      stb_cmd <= 1'b0;
      wr(`WIOM_A_INCFG, 32'h01);
      pulses(2'h1, 0, 0);
      stb_cmd <= 1'b1;
      pulses(2'h1, 1, 0);
      rd(`WIOM_A_TARE, 32'h1F4);
      pulses(2'h0, 0, 0);
      wr(`WIOM_A_INCFG, 32'h22);
      pulses(2'h1, 0, 0);
      rd(`WIOM_A_TARE, 32'h0);
      pulses(2'h0, 0, 0);
      wr(`WIOM_A_INCFG, 32'h23);
      zt(32'h0, 24'h32, 1);
      zt(32'h0, 24'h96, 0);
      zt(32'h4, 24'hF, 1);
      zt(32'h4, 24'h32, 0);
      wr(`WIOM_A_MODE, 32'h0);
      wr(`WIOM_A_OUTCFG, 32'h04031202);
      dchk(4'h2);
      stb_cmd <= 1'b0;
      flt_cmd <= 3'h4;
      sw_cmd <= 2'h1;
      dchk(4'h5);
      for (int i = 0; i < 3; i++) begin
         flt_cmd <= 3'h1 << i;
         dchk(4'h5);
      end
      flt_cmd <= 3'h0;
      wr(`WIOM_A_OUTCFG, 32'h14041404);
      dchk(4'hF);
      sw_cmd <= 2'h2;
      dchk(4'h0);
      wr(`WIOM_A_OUTCFG, 32'h05250525);
      dchk(4'h5);
      wr(`WIOM_A_SPBASE, 32'hC8);
      wr(`WIOM_A_SPBASE + 12'h004, 32'h64);
      wr(`WIOM_A_SPBASE + 12'h008, 32'h1);
      wr(`WIOM_A_SPBASE + 12'h00C, 32'h1F4);
      wr(`WIOM_A_SPBASE + 12'h010, 32'h190);
      wr(`WIOM_A_SPBASE + 12'h014, 32'h1);
      wr(`WIOM_A_OUTCFG, 32'h0101);
      wt_cmd <= 24'sh96;
      dchk(4'h1);
      wt_cmd <= 24'sh1C2;
      dchk(4'h2);
      // set point 1 in hysteresis: set above high, held between, cleared below low
      wr(`WIOM_A_SPBASE + 12'h008, 32'h0);
      dchk(4'h3);
      wt_cmd <= 24'sh96;
      dchk(4'h1);
      wt_cmd <= 24'sh0;
      dchk(4'h0);
      wt_cmd <= 24'sh96;
      wr(`WIOM_A_OUTCFG, 32'h09);
      dchk(4'h0);
      // filling: outputs cycle, coarse, fine; target 500, fine amount 100, start delay 3
      wr(`WIOM_A_MODE, 32'h1);
      wr(`WIOM_A_TARGET, 32'h1F4);
      wr(`WIOM_A_FINE, 32'h03000064);
      rd(`WIOM_A_FINE, 32'h03000064);
      wr(`WIOM_A_OUTCFG, 32'h00080906);
      wt_cmd <= 24'sh0;
      wr(`WIOM_A_CMD, 32'h1);
      dchk(4'h3);
      wt_cmd <= 24'sh190;
      dchk(4'h5);
      wt_cmd <= 24'sh1F4;
      dchk(4'h0);
      wt_cmd <= 24'sh0;
      wr(`WIOM_A_CMD, 32'h1);
      dchk(4'h3);
      wr(`WIOM_A_CMD, 32'h2);
      dchk(4'h0);
      wrap_up;
   end
endmodule // test_weigh_io_function_mapper

// file: bench/wiom_chk_assertions.sv
`timescale 1ns/10ps
module wiom_chk (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] dout,
   input wire logic tare_evt,
   input wire logic zero_evt
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_tare_pulse; tare_evt |=> !tare_evt; endproperty
   property p_zero_pulse; zero_evt |=> !zero_evt; endproperty
   property p_ready_one; pready |=> !pready; endproperty
   property p_setup_ans; psel && !penable |=> pready; endproperty
   property p_ready_cause; pready |-> $past(psel) && penable; endproperty
   property p_err_ready; pslverr |-> pready; endproperty
   property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
   property p_rst_quiet; $rose(nrst) |-> dout == 4'h0 && !tare_evt && !zero_evt; endproperty
   a_tare_pulse: assert property (p_tare_pulse) else $error("tare trigger longer than one cycle");
   a_zero_pulse: assert property (p_zero_pulse) else $error("zero trigger longer than one cycle");
   a_ready_one: assert property (p_ready_one) else $error("pready held too long");
   a_setup_ans: assert property (p_setup_ans) else $error("no answer after setup");
   a_ready_cause: assert property (p_ready_cause) else $error("pready without a transfer");
   a_err_ready: assert property (p_err_ready) else $error("pslverr outside access");
   a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
   c_tare: cover property (tare_evt);
   c_zero: cover property (zero_evt);
   c_err: cover property (pslverr);
endmodule // wiom_chk
bind wiom_top wiom_chk wiom_chk_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .dout(dout), .tare_evt(tare_evt), .zero_evt(zero_evt));

// file: bench/wiom_plant.sv
`timescale 1ns/10ps
// plant side: switches, scale front end and fault lamps, registered like field wiring
module wiom_plant (
   input wire logic ref_clk,
   input wire logic [1:0] sw_cmd,
   input wire logic signed [23:0] wt_cmd,
   input wire logic stb_cmd,
   input wire logic [2:0] flt_cmd,
   output logic [1:0] din,
   output logic signed [23:0] gross_wt,
   output logic stable,
   output logic [2:0] fault_flags
);
   initial begin
      din = 2'h0;
      gross_wt = 24'sh0;
      stable = 1'b1;
      fault_flags = 3'h0;
   end
   always @(posedge ref_clk) begin
      din <= sw_cmd;
      gross_wt <= wt_cmd;
      stable <= stb_cmd;
      fault_flags <= flt_cmd;
   end
endmodule // wiom_plant

// file: core/wiom_top.v
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "wiom_consts.vh"
// Overview of operation
// - inputs set to no function trigger no action, but still show on image outputs
// - tare may be assigned to either or both inputs independently
// - tare edge is rising in positive logic, falling in negative
// - tare waits for stability unless the criterion is disabled
// - tare cancel input clears stored tare on its active edge
// - zero on either or both inputs, polarity edge, volatile value
// - zero accepted within 10 percent capacity, or 2 percent legal-for-trade
// - zero waits for stability unless the criterion is disabled
// - each output has its own polarity
// - set point output n is tied to comparator n
// - comparators have high and low thresholds, hysteresis or window
// - comparators use gross or net weight, chosen per set point
// - motion output follows stability indication
// - fault output mirrors range, over capacity and under capacity flags
// - outputs 1,3 copy input 1, outputs 2,4 copy input 2, true or inverted
// - level on request output takes the master's commanded level
// - dosing feed outputs follow one of eight selectable orders
// - filling mode sequences the dosing cycle on four outputs
// - per-input polarity and one common adjustable debounce time
// - after start and start delay the cycle begins, cycle output set
// - coarse feed stops at once when weight reaches target minus fine
module wiom_top #(
   parameter DEB_CYC = `WIOM_DEB_NS / `WIOM_CLK_NS
) (
   input wire ref_clk,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [1:0] din,
   input wire signed [23:0] gross_wt,
   input wire stable,
   input wire [2:0] fault_flags,
   output reg [3:0] dout,
   output reg tare_evt,
   output reg zero_evt
);
   ////////////////////////////////////////////////////////////////////////
   // registers: mode[1:0] lft[2]; incfg per input {stab_off,pol,func[3:0]} in 8 bits;
   // outcfg per output {req,pol,func[3:0]}; sp cfg {src,win}; feed order[2:0]
   reg [31:0] mode_r, incfg_r, outcfg_r, feed_r, cap_r, target_r, fine_r;
   reg signed [23:0] tare_r, zero_r;
   reg [23:0] sp_hi_r [0:3];
   reg [23:0] sp_lo_r [0:3];
   reg [1:0] sp_cfg_r [0:3];
   reg [3:0] sp_state_r;
   reg [1:0] s1_r, s2_r, s3_r;
   reg [1:0] deb_r;
   reg [31:0] deb_cnt_r;
   reg tare_pend_r, zero_pend_r, zero_rej_r;
   reg start_pend_r, cyc_r, coarse_r, fine_on_r, high_r;
   reg [31:0] dly_cnt_r;
   reg [3:0] dout_nxt;
   reg [1:0] trig;
   // one loop index per process, so no variable is driven from two processes
   integer i, j, k, m, p;
   wire signed [23:0] net_wt = gross_wt - tare_r;
   wire [1:0] md = mode_r[1:0];
   wire dosing = (md == `WIOM_M_FILL) || (md == `WIOM_M_UNLD);
   wire wr = psel && penable && pwrite && pready;
   wire rd_ok = paddr[11:2] <= (`WIOM_A_SPBASE >> 2) + 10'd11;
   function [3:0] fn;
      input [31:0] cfg;
      input integer n;
      fn = cfg[n*8 +: 4];
   endfunction
   // mode permission of an input function
   function in_ok;
      input [3:0] f;
      input [1:0] m;
      case (f)
         `WIOM_I_NONE, `WIOM_I_TARE, `WIOM_I_CTARE, `WIOM_I_ZERO: in_ok = 1'b1;
         `WIOM_I_XMIT, `WIOM_I_WIN: in_ok = (m == `WIOM_M_XMIT);
         `WIOM_I_SUSP, `WIOM_I_EMPTY: in_ok = (m == `WIOM_M_FILL);
         default: in_ok = (m == `WIOM_M_FILL) || (m == `WIOM_M_UNLD);
      endcase
   endfunction
   function signed [24:0] absd;
      input signed [23:0] v;
      absd = v[23] ? -{v[23], v} : {v[23], v};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // apb slave, one wait-free access: pready high in access phase
   always @(posedge ref_clk) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !rd_ok;
         prdata <= 32'h00000000;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `WIOM_A_MODE: prdata <= mode_r;
               `WIOM_A_INCFG: prdata <= incfg_r;
               `WIOM_A_OUTCFG: prdata <= outcfg_r;
               `WIOM_A_FEED: prdata <= feed_r;
               `WIOM_A_CAP: prdata <= cap_r;
               `WIOM_A_STATUS: prdata <= {20'h00000, zero_rej_r, tare_pend_r, zero_pend_r, cyc_r,
                                         high_r, coarse_r, fine_on_r, fault_flags, deb_r};
               `WIOM_A_TARE: prdata <= {{8{tare_r[23]}}, tare_r};
               `WIOM_A_ZERO: prdata <= {{8{zero_r[23]}}, zero_r};
               `WIOM_A_TARGET: prdata <= target_r;
               `WIOM_A_FINE: prdata <= fine_r;
               default: begin
                  for (i = 0; i < 4; i = i + 1) begin
                     if (paddr == `WIOM_A_SPBASE + i*12) prdata <= {8'h00, sp_hi_r[i]};
                     if (paddr == `WIOM_A_SPBASE + i*12 + 4) prdata <= {8'h00, sp_lo_r[i]};
                     if (paddr == `WIOM_A_SPBASE + i*12 + 8) prdata <= {30'h00000000, sp_cfg_r[i]};
                  end
               end
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // input conditioning
   always @(posedge ref_clk) begin
      if (!nrst) begin
         s1_r <= 2'h0;
         s2_r <= 2'h0;
         s3_r <= 2'h0;
         deb_r <= 2'h0;
         deb_cnt_r <= 32'h00000000;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         // common debounce: a change must hold for DEB_CYC+1 cycles on both inputs
         if (s2_r == deb_r) deb_cnt_r <= 32'h00000000;
         else if (deb_cnt_r >= DEB_CYC) begin
            deb_r <= s2_r;
            deb_cnt_r <= 32'h00000000;
         end else deb_cnt_r <= deb_cnt_r + 32'h00000001;
         s3_r <= deb_r;
      end
   end
   // trig[n]: active edge of input n, one cycle
   always @* begin
      trig = 2'h0;
      for (j = 0; j < 2; j = j + 1) begin
         if (incfg_r[j*8+4]) trig[j] = s3_r[j] && !deb_r[j];
         else trig[j] = !s3_r[j] && deb_r[j];
         if (fn(incfg_r, j) == `WIOM_I_NONE || !in_ok(fn(incfg_r, j), md)) trig[j] = 1'b0;
      end
   end
   wire tare_hit = (trig[0] && fn(incfg_r, 0) == `WIOM_I_TARE) || (trig[1] && fn(incfg_r, 1) == `WIOM_I_TARE);
   wire ctare_hit = (trig[0] && fn(incfg_r, 0) == `WIOM_I_CTARE) || (trig[1] && fn(incfg_r, 1) == `WIOM_I_CTARE);
   wire zero_hit = (trig[0] && fn(incfg_r, 0) == `WIOM_I_ZERO) || (trig[1] && fn(incfg_r, 1) == `WIOM_I_ZERO);
   wire start_hit = (trig[0] && fn(incfg_r, 0) == `WIOM_I_START) || (trig[1] && fn(incfg_r, 1) == `WIOM_I_START)
                    || (wr && paddr == `WIOM_A_CMD && pwdata[0]);
   wire stop_hit = (trig[0] && fn(incfg_r, 0) == `WIOM_I_STOP) || (trig[1] && fn(incfg_r, 1) == `WIOM_I_STOP)
                   || (wr && paddr == `WIOM_A_CMD && pwdata[1]);
   wire stab_ok = stable || incfg_r[5] || incfg_r[13];
   // zero window: |gross| * 100 <= capacity * pct
   wire [7:0] zpct = mode_r[2] ? `WIOM_ZPCT_LFT : `WIOM_ZPCT_STD;
   wire [47:0] z_lhs = absd(gross_wt) * `WIOM_PCT_DIV;
   wire [47:0] z_rhs = cap_r[23:0] * zpct;
   wire zero_in = z_lhs <= z_rhs;
   ////////////////////////////////////////////////////////////////////////
   // configuration, tare and zero
   always @(posedge ref_clk) begin
      if (!nrst) begin
         mode_r <= 32'h00000000;
         incfg_r <= 32'h00000000;
         outcfg_r <= 32'h00000000;
         feed_r <= 32'h00000000;
         cap_r <= 32'h00000000;
         target_r <= 32'h00000000;
         fine_r <= 32'h00000000;
         tare_r <= 24'h000000;
         zero_r <= 24'h000000;
         tare_pend_r <= 1'b0;
         zero_pend_r <= 1'b0;
         zero_rej_r <= 1'b0;
         tare_evt <= 1'b0;
         zero_evt <= 1'b0;
         for (k = 0; k < 4; k = k + 1) begin
            sp_hi_r[k] <= 24'h000000;
            sp_lo_r[k] <= 24'h000000;
            sp_cfg_r[k] <= 2'h0;
         end
      end else begin
         tare_evt <= 1'b0;
         zero_evt <= 1'b0;
         if (wr) begin
            case (paddr)
               `WIOM_A_MODE: mode_r <= {29'h00000000, pwdata[2:0]};
               `WIOM_A_INCFG: incfg_r <= {16'h0000, pwdata[15:0]};
               `WIOM_A_OUTCFG: outcfg_r <= pwdata;
               `WIOM_A_FEED: feed_r <= {29'h00000000, pwdata[2:0]};
               `WIOM_A_CAP: cap_r <= {8'h00, pwdata[23:0]};
               `WIOM_A_TARGET: target_r <= {8'h00, pwdata[23:0]};
               // top byte holds the start delay, so the whole word is kept
               `WIOM_A_FINE: fine_r <= pwdata;
               default: begin
                  for (k = 0; k < 4; k = k + 1) begin
                     if (paddr == `WIOM_A_SPBASE + k*12) sp_hi_r[k] <= pwdata[23:0];
                     if (paddr == `WIOM_A_SPBASE + k*12 + 4) sp_lo_r[k] <= pwdata[23:0];
                     if (paddr == `WIOM_A_SPBASE + k*12 + 8) sp_cfg_r[k] <= pwdata[1:0];
                  end
               end
            endcase
         end
         // pending tare: taken when stable; a new edge re-arms
         if (tare_pend_r && stab_ok) begin
            tare_r <= gross_wt;
            tare_evt <= 1'b1;
            tare_pend_r <= tare_hit;
         end else if (tare_hit) tare_pend_r <= 1'b1;
         if (ctare_hit) begin
            tare_r <= 24'h000000;
            tare_pend_r <= 1'b0;
         end
         if (zero_pend_r && stab_ok) begin
            zero_pend_r <= zero_hit;
            if (zero_in) begin
               zero_r <= gross_wt;
               zero_evt <= 1'b1;
               zero_rej_r <= 1'b0;
            end else zero_rej_r <= 1'b1;
         end else if (zero_hit) zero_pend_r <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // set point comparators
   always @(posedge ref_clk) begin
      if (!nrst) sp_state_r <= 4'h0;
      else begin
         for (m = 0; m < 4; m = m + 1) begin
            if (sp_cfg_r[m][0])
               sp_state_r[m] <= ($signed(sp_cfg_r[m][1] ? net_wt : gross_wt) >= $signed(sp_lo_r[m])) &&
                                ($signed(sp_cfg_r[m][1] ? net_wt : gross_wt) <= $signed(sp_hi_r[m]));
            else if ($signed(sp_cfg_r[m][1] ? net_wt : gross_wt) >= $signed(sp_hi_r[m]))
               sp_state_r[m] <= 1'b1;
            else if ($signed(sp_cfg_r[m][1] ? net_wt : gross_wt) < $signed(sp_lo_r[m]))
               sp_state_r[m] <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // dosing sequencer: start delay, feeds, coarse cut at target minus fine
   wire signed [24:0] coarse_lvl = $signed({target_r[23], target_r[23:0]}) - $signed({fine_r[23], fine_r[23:0]});
   wire at_coarse = $signed({net_wt[23], net_wt}) >= coarse_lvl;
   wire at_target = $signed({net_wt[23], net_wt}) >= $signed({target_r[23], target_r[23:0]});
   always @(posedge ref_clk) begin
      if (!nrst) begin
         start_pend_r <= 1'b0;
         cyc_r <= 1'b0;
         coarse_r <= 1'b0;
         fine_on_r <= 1'b0;
         high_r <= 1'b0;
         dly_cnt_r <= 32'h00000000;
      end else if (!dosing || stop_hit) begin
         start_pend_r <= 1'b0;
         cyc_r <= 1'b0;
         coarse_r <= 1'b0;
         fine_on_r <= 1'b0;
         high_r <= 1'b0;
      end else if (start_hit && !cyc_r && !start_pend_r) begin
         start_pend_r <= 1'b1;
         dly_cnt_r <= fine_r[31:24] == 8'h00 ? 32'h00000000 : {24'h000000, fine_r[31:24]};
      end else if (start_pend_r) begin
         if (dly_cnt_r == 32'h00000000) begin
            start_pend_r <= 1'b0;
            cyc_r <= 1'b1;
            coarse_r <= feed_r[2:0] != 3'h3;
            fine_on_r <= feed_r[2:0] == 3'h1 || feed_r[2:0] == 3'h3 || feed_r[2:0] == 3'h4 || feed_r[2:0] == 3'h6;
            high_r <= feed_r[2:0] >= 3'h5;
         end else dly_cnt_r <= dly_cnt_r - 32'h00000001;
      end else if (cyc_r) begin
         if (at_coarse) begin
            coarse_r <= 1'b0;
            high_r <= 1'b0;
            fine_on_r <= feed_r[2:0] != 3'h2;
         end
         if (at_target) begin
            fine_on_r <= 1'b0;
            cyc_r <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // output mapping
   always @* begin
      for (p = 0; p < 4; p = p + 1) begin
         case (fn(outcfg_r, p))
            `WIOM_O_SP: dout_nxt[p] = sp_state_r[p];
            `WIOM_O_MOTION: dout_nxt[p] = !stable;
            `WIOM_O_FAULT: dout_nxt[p] = |fault_flags;
            `WIOM_O_IMAGE: dout_nxt[p] = deb_r[p % 2];
            `WIOM_O_REQ: dout_nxt[p] = outcfg_r[p*8+5];
            // cycle in progress only once the start delay has run out
            `WIOM_O_CYCLE: dout_nxt[p] = dosing && cyc_r;
            `WIOM_O_FINE: dout_nxt[p] = dosing && fine_on_r;
            `WIOM_O_COARSE: dout_nxt[p] = dosing && coarse_r;
            `WIOM_O_HIGH: dout_nxt[p] = dosing && high_r;
            `WIOM_O_EMPTY: dout_nxt[p] = 1'b0 && (md == `WIOM_M_FILL);
            `WIOM_O_RELOAD: dout_nxt[p] = 1'b0 && (md == `WIOM_M_UNLD);
            default: dout_nxt[p] = 1'b0;
         endcase
         if (fn(outcfg_r, p) != `WIOM_O_NONE) dout_nxt[p] = dout_nxt[p] ^ outcfg_r[p*8+4];
      end
   end
   always @(posedge ref_clk) begin
      if (!nrst) dout <= 4'h0;
      else dout <= dout_nxt;
   end
endmodule // wiom_top

// file: pkg/wiom_consts.vh
`ifndef WIOM_CONSTS_VH
`define WIOM_CONSTS_VH
// register byte addresses
`define WIOM_A_MODE     12'h000
`define WIOM_A_INCFG    12'h004
`define WIOM_A_OUTCFG   12'h008
`define WIOM_A_FEED     12'h00C
`define WIOM_A_CAP      12'h010
`define WIOM_A_CMD      12'h014
`define WIOM_A_STATUS   12'h018
`define WIOM_A_TARE     12'h01C
`define WIOM_A_ZERO     12'h020
`define WIOM_A_TARGET   12'h024
`define WIOM_A_FINE     12'h028
`define WIOM_A_SPBASE   12'h040
// operating modes
`define WIOM_M_XMIT     2'h0
`define WIOM_M_FILL     2'h1
`define WIOM_M_UNLD     2'h2
// input functions
`define WIOM_I_NONE     4'h0
`define WIOM_I_TARE     4'h1
`define WIOM_I_CTARE    4'h2
`define WIOM_I_ZERO     4'h3
`define WIOM_I_XMIT     4'h4
`define WIOM_I_WIN      4'h5
`define WIOM_I_START    4'h6
`define WIOM_I_STOP     4'h7
`define WIOM_I_CLR      4'h8
`define WIOM_I_SUSP     4'h9
`define WIOM_I_EMPTY    4'hA
`define WIOM_I_DZERO    4'hB
`define WIOM_I_PEAK     4'hC
// output functions
`define WIOM_O_NONE     4'h0
`define WIOM_O_SP       4'h1
`define WIOM_O_MOTION   4'h2
`define WIOM_O_FAULT    4'h3
`define WIOM_O_IMAGE    4'h4
`define WIOM_O_REQ      4'h5
`define WIOM_O_CYCLE    4'h6
`define WIOM_O_RESULT   4'h7
`define WIOM_O_FINE     4'h8
`define WIOM_O_COARSE   4'h9
`define WIOM_O_HIGH     4'hA
`define WIOM_O_EMPTY    4'hB
`define WIOM_O_RELOAD   4'hC
// limits, percent of capacity
`define WIOM_ZPCT_STD   8'd10
`define WIOM_ZPCT_LFT   8'd2
`define WIOM_PCT_DIV    32'd100
// debounce default, ns
`define WIOM_DEB_NS     32'd10000000
`define WIOM_CLK_NS     32'd8
`endif
